// file: core/sse_core.sv
// module: sync serial channel with error detection, AHB-Lite register slave
// Operation
// R1 - overrun and phase errors in both modes; underrun and baud errors in slave only
// R2 - error sets its flag; with enable set it also sets error request
// R3 - flags stay until software clears; error request clears on service
// R4 - request repeats while any enabled flag remains set
// R5 - overrun when frame completes while receive buffer still unread
// R6 - overrun overwrites receive buffer with the new frame
// R7 - phase error when data changes from one sample before to two after latch edge
// R8 - phase check on master input pin as master, slave input pin as slave
// R9 - slave baud error when shift clock above double or below half rate
// R10 - software programs slave baud rate equal to master rate
// R11 - baud error with auto reinit enabled reinitialises the channel
// R12 - slave underrun when transfer starts with transmit buffer not rewritten
// R13 - on underrun slave shifts out unchanged shift register contents
// R14 - unselected open-drain slaves get all ones in transmit buffer
// R15 - software loads slave transmit buffer before every transfer
// R16 - transmit, receive and error requests, each own control and line
// R17 - four error flags readable in channel control register
// R18 - baud generator counts down at half clock, reloaded from 16-bit value
// R19 - data pin roles swap automatically with master or slave mode
// R20 - flags and request set in the cycle after detection
// R21 - detection wins over a same-cycle software clear
module sse_core (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [sse_pkg::SSE_AW-1:0] haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [sse_pkg::SSE_DW-1:0] hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic      [sse_pkg::SSE_DW-1:0] hrdata,
	input  wire logic                      sclk_i,
	output logic                           sclk_o,
	output logic                           sclk_oe,
	input  wire logic                      master_in_slave_out_pin_i,
	output logic                           master_in_slave_out_pin_o,
	output logic                           master_in_slave_out_pin_oe,
	input  wire logic                      master_out_slave_in_pin_i,
	output logic                           master_out_slave_in_pin_o,
	output logic                           master_out_slave_in_pin_oe,
	input  wire logic [sse_pkg::SSE_NIRQ-1:0] irq_ack,
	output logic      [sse_pkg::SSE_NIRQ-1:0] irq
);
	import sse_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// ==========================================================
	// state declarations
	sse_state_t                 st_q;
	logic [SSE_CTL_CFGW-1:0]    cfg_q;
	logic [SSE_NERR-1:0]        err_q, det, clr;
	logic [15:0]                tb_q, rb_q, sr_q, rld_q, brg_q, rx_word;
	logic [4:0]                 cnt_q;
	logic [SSE_PER_W-1:0]       per_q;
	logic [SSE_PH_PRE+SSE_PH_POST-1:0] hist_q;
	logic [SSE_PH_POST-1:0]     edge_q;
	logic                       rb_full_q, tx_pend_q, armed_q, dout_q, pre_q, msclk_q, mprev_q;
	logic                       sclk_s1_q, sclk_s2_q, sclk_s3_q, din_s;
	logic [1:0]                 pin_s1_q, pin_s2_q;
	logic                       wr_q, acc, rb_rd, en, ms, busy, rise, fall, start_s, shift;
	logic                       last, ovr_det, ph_det, bd_det, ur_det, reinit, ld;
	logic [7:0]                 wa_q;
	logic [SSE_DW-1:0]          rd_d;
	logic [15:0]                wd;
	logic [SSE_NIRQ-1:0]        req_q, ie_q, req_set, wr_ic;

	assign en   = cfg_q[SSE_CTL_EN];
	assign ms   = cfg_q[SSE_CTL_MS];
	assign busy = (st_q == SSE_BUSY);
	assign wd   = hwdata[15:0];

	// ==========================================================
	// bus slave: zero wait, always OKAY; write lands in data phase
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign acc       = hsel & htrans[1] & hready;
	assign rb_rd     = acc & ~hwrite & hit(haddr[7:0], SSE_OFF_RB);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
		end else begin
			wr_q <= acc & hwrite;
			wa_q <= haddr[7:0];
		end
	end

	always_comb begin
		rd_d = '0;
		if (hit(haddr[7:0], SSE_OFF_CTRL)) begin
			rd_d[15:0] = {err_q, busy, 2'b00, cfg_q}; // R17
		end else if (hit(haddr[7:0], SSE_OFF_TB)) begin
			rd_d[15:0] = tb_q;
		end else if (hit(haddr[7:0], SSE_OFF_RB)) begin
			rd_d[15:0] = rb_q;
		end else if (hit(haddr[7:0], SSE_OFF_BRG)) begin
			rd_d[15:0] = en ? brg_q : rld_q;
		end else if (hit(haddr[7:0], SSE_OFF_IC[SSE_IRQ_TX])) begin
			rd_d[1:0] = {ie_q[SSE_IRQ_TX], req_q[SSE_IRQ_TX]};
		end else if (hit(haddr[7:0], SSE_OFF_IC[SSE_IRQ_RX])) begin
			rd_d[1:0] = {ie_q[SSE_IRQ_RX], req_q[SSE_IRQ_RX]};
		end else if (hit(haddr[7:0], SSE_OFF_IC[SSE_IRQ_ER])) begin
			rd_d[1:0] = {ie_q[SSE_IRQ_ER], req_q[SSE_IRQ_ER]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (acc & ~hwrite) begin
			hrdata <= rd_d;
		end
	end

	// ==========================================================
	// software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= SSE_CFG_RST;
			rld_q <= SSE_BRG_RST;
			tb_q  <= SSE_BUF_RST;
		end else if (wr_q) begin
			if (hit(wa_q, SSE_OFF_CTRL)) begin
				cfg_q <= wd[SSE_CTL_CFGW-1:0];
			end else if (hit(wa_q, SSE_OFF_TB)) begin
				tb_q <= wd;
			end else if (hit(wa_q, SSE_OFF_BRG) && !en) begin
				// reload is only writable while the channel is off
				rld_q <= wd;
			end
		end
	end

	// ==========================================================
	// pin synchronisers; both data pins synced, chosen by mode afterwards
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= 3'h0;
			pin_s1_q <= 2'h0;
			pin_s2_q <= 2'h0;
		end else begin
			sclk_s1_q <= sclk_i;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			pin_s1_q  <= {master_in_slave_out_pin_i, master_out_slave_in_pin_i};
			pin_s2_q  <= pin_s1_q;
		end
	end

	// same two-stage latency as the clock, so the phase window stays aligned
	assign din_s = ms ? pin_s2_q[1] : pin_s2_q[0]; // R8 R19

	// ==========================================================
	// baud generator and master clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q   <= 1'b0;
			brg_q   <= SSE_BRG_RST;
			msclk_q <= 1'b0;
			mprev_q <= 1'b0;
		end else begin
			mprev_q <= msclk_q;
			msclk_q <= busy & ms & (brg_q <= (rld_q >> 1));
			if (!busy) begin
				pre_q <= 1'b0;
				brg_q <= rld_q;
			end else begin
				pre_q <= ~pre_q;
				if (pre_q) begin
					brg_q <= (brg_q == 16'h0000) ? rld_q : brg_q - 16'h0001; // R18
				end
			end
		end
	end

	assign rise    = en & (ms ? (msclk_q & ~mprev_q) : (sclk_s2_q & ~sclk_s3_q));
	assign fall    = en & (ms ? (~msclk_q & mprev_q) : (~sclk_s2_q & sclk_s3_q));
	assign start_s = en & ~ms & ~busy & rise;
	assign shift   = rise & (busy | start_s);
	assign last    = shift & (cnt_q == 5'd15);
	assign rx_word = {sr_q[14:0], din_s};
	assign ld      = en & ~busy & tx_pend_q & ~start_s;

	// ==========================================================
	// error detection
	assign ovr_det = last & rb_full_q & ~rb_rd; // R1 R5
	assign ph_det  = en & edge_q[SSE_PH_POST-1] & ~(&{hist_q, din_s} | ~|{hist_q, din_s}); // R7
	assign bd_det  = en & ~ms & busy & (rise ? (per_q < {3'b000, rld_q})
		: (per_q >= (({3'b000, rld_q} + 19'd1) << 2))); // R1 R9
	assign ur_det  = start_s & ~armed_q; // R1 R12
	assign reinit  = ~en | (bd_det & cfg_q[SSE_CTL_AREN]); // R11

	always_comb begin
		det = '0;
		det[SSE_E_RE] = ovr_det;
		det[SSE_E_PE] = ph_det;
		det[SSE_E_BE] = bd_det;
		det[SSE_E_TE] = ur_det;
	end

	assign clr = (wr_q && hit(wa_q, SSE_OFF_CTRL)) ? wd[SSE_CTL_FLG +: SSE_NERR] : '0;

	// detection wins over a same-cycle write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_q <= '0;
		end else begin
			err_q <= (err_q & ~clr) | det; // R2 R3 R20 R21
		end
	end

	// phase window: samples one before to two after each latch edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist_q <= '0;
			edge_q <= '0;
			per_q  <= '0;
		end else begin
			hist_q <= {hist_q[SSE_PH_PRE+SSE_PH_POST-2:0], din_s};
			edge_q <= {edge_q[SSE_PH_POST-2:0], shift};
			if (shift) begin
				per_q <= '0;
			end else if (busy && per_q != '1) begin
				per_q <= per_q + 19'd1;
			end
		end
	end

	// ==========================================================
	// shift engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q      <= SSE_IDLE;
			cnt_q     <= 5'd0;
			sr_q      <= SSE_BUF_RST;
			dout_q    <= 1'b0;
			rb_q      <= SSE_BUF_RST;
			rb_full_q <= 1'b0;
			tx_pend_q <= 1'b0;
			armed_q   <= 1'b0;
		end else begin
			if (wr_q && hit(wa_q, SSE_OFF_TB)) begin
				tx_pend_q <= 1'b1;
			end else if (ld) begin
				tx_pend_q <= 1'b0;
			end
			if (last) begin
				rb_q      <= rx_word; // R6
				rb_full_q <= 1'b1;
			end else if (rb_rd) begin
				rb_full_q <= 1'b0;
			end
			if (fall || !busy) begin
				dout_q <= sr_q[15];
			end
			if (shift) begin
				// underrun leaves sr_q as last received frame
				sr_q <= rx_word; // R13
			end else if (ld) begin
				sr_q <= tb_q;
			end
			if (ld) begin
				armed_q <= 1'b1;
			end else if (start_s || (ms && !busy && en && armed_q)) begin
				armed_q <= 1'b0;
			end
			case (st_q)
				SSE_IDLE: begin
					cnt_q <= 5'd0;
					if (start_s) begin
						st_q  <= SSE_BUSY;
						cnt_q <= 5'd1;
					end else if (en && ms && armed_q) begin
						st_q <= SSE_BUSY;
					end
				end
				SSE_BUSY: begin
					if (reinit || last) begin
						st_q  <= SSE_IDLE;
						cnt_q <= 5'd0;
					end else if (shift) begin
						cnt_q <= cnt_q + 5'd1;
					end
				end
				default: begin
					st_q <= SSE_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// pins: drivers swap with mode
	assign sclk_o                     = msclk_q;
	assign sclk_oe                    = en & ms;
	assign master_out_slave_in_pin_o  = dout_q;
	assign master_out_slave_in_pin_oe = en & ms; // R19
	assign master_in_slave_out_pin_o  = dout_q;
	assign master_in_slave_out_pin_oe = en & ~ms; // R19

	// ==========================================================
	// interrupt request flags: transmit, receive, error
	assign req_set[SSE_IRQ_TX] = ld;
	assign req_set[SSE_IRQ_RX] = last;
	// keeps requesting while an enabled flag stays set
	assign req_set[SSE_IRQ_ER] = |((det | err_q) & cfg_q[SSE_CTL_EEN +: SSE_NERR]); // R2 R4

	genvar gi;
	generate
		for (gi = 0; gi < SSE_NIRQ; gi++) begin : g_irq
			assign wr_ic[gi] = wr_q & hit(wa_q, SSE_OFF_IC[gi]);
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					req_q[gi] <= 1'b0;
					ie_q[gi]  <= 1'b0;
				end else begin
					if (wr_ic[gi]) begin
						ie_q[gi] <= wd[SSE_IC_IE];
					end
					if (req_set[gi]) begin
						req_q[gi] <= 1'b1; // R16
					end else if (irq_ack[gi]) begin
						req_q[gi] <= 1'b0; // R3
					end else if (wr_ic[gi]) begin
						req_q[gi] <= wd[SSE_IC_REQ];
					end
				end
			end
			assign irq[gi] = req_q[gi] & ie_q[gi]; // R16
		end
	endgenerate

	// ==========================================================
	// checks
	property p_ovr;
		@(posedge hclk) disable iff (!hresetn)
		ovr_det |=> err_q[SSE_E_RE] && rb_full_q;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun flag missing"); // R5

	property p_rbnew;
		@(posedge hclk) disable iff (!hresetn)
		last |=> rb_q == $past(rx_word);
	endproperty
	a_rbnew: assert property (p_rbnew) else $error("receive buffer not replaced"); // R6

	property p_slv_only;
		@(posedge hclk) disable iff (!hresetn)
		ms |-> !det[SSE_E_BE] && !det[SSE_E_TE];
	endproperty
	a_slv_only: assert property (p_slv_only) else $error("slave error in master"); // R1

	property p_ph;
		@(posedge hclk) disable iff (!hresetn)
		ph_det |=> err_q[SSE_E_PE] ##0 $past(edge_q[SSE_PH_POST-1]);
	endproperty
	a_ph: assert property (p_ph) else $error("phase flag missing"); // R7

	property p_req;
		@(posedge hclk) disable iff (!hresetn)
		|(det & cfg_q[SSE_CTL_EEN +: SSE_NERR]) |=> req_q[SSE_IRQ_ER];
	endproperty
	a_req: assert property (p_req) else $error("error request late"); // R2

	property p_sticky;
		@(posedge hclk) disable iff (!hresetn)
		clr == '0 |=> (err_q & $past(err_q)) == $past(err_q);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped"); // R3

	property p_repeat;
		@(posedge hclk) disable iff (!hresetn)
		|(err_q & cfg_q[SSE_CTL_EEN +: SSE_NERR]) |=> req_q[SSE_IRQ_ER] [*2];
	endproperty
	a_repeat: assert property (p_repeat) else $error("request not repeated"); // R4

	property p_setwins;
		@(posedge hclk) disable iff (!hresetn)
		(det[SSE_E_TE] && clr[SSE_E_TE]) |=> err_q[SSE_E_TE];
	endproperty
	a_setwins: assert property (p_setwins) else $error("clear beat detection"); // R21

	property p_reinit;
		@(posedge hclk) disable iff (!hresetn)
		(bd_det && cfg_q[SSE_CTL_AREN]) |=> st_q == SSE_IDLE && err_q[SSE_E_BE];
	endproperty
	a_reinit: assert property (p_reinit) else $error("no reinit on baud error"); // R11

	property p_under;
		@(posedge hclk) disable iff (!hresetn)
		ur_det |=> err_q[SSE_E_TE] && sr_q == $past(rx_word);
	endproperty
	a_under: assert property (p_under) else $error("underrun handling wrong"); // R12
endmodule : sse_core

// file: core/sse_pkg.sv
// package: register map, field layout and timing constants of the serial error block
package sse_pkg;
	// ==========================================================
	// bus and register map
	localparam int         SSE_DW       = 32;
	localparam int         SSE_AW       = 32;
	localparam logic [7:0] SSE_OFF_CTRL = 8'h00;
	localparam logic [7:0] SSE_OFF_TB   = 8'h04;
	localparam logic [7:0] SSE_OFF_RB   = 8'h08;
	localparam logic [7:0] SSE_OFF_BRG  = 8'h0C;
	localparam logic [7:0] SSE_OFF_IC [0:2] = '{8'h10, 8'h14, 8'h18};
	// ==========================================================
	// channel control fields
	localparam int SSE_CTL_EN   = 0;
	localparam int SSE_CTL_MS   = 1;
	localparam int SSE_CTL_EEN  = 4;
	localparam int SSE_CTL_AREN = 8;
	localparam int SSE_CTL_CFGW = 9;
	localparam int SSE_CTL_BUSY = 11;
	localparam int SSE_CTL_FLG  = 12;
	// error index order inside flag and enable groups
	localparam int SSE_NERR = 4;
	localparam int SSE_E_RE = 0;
	localparam int SSE_E_PE = 1;
	localparam int SSE_E_BE = 2;
	localparam int SSE_E_TE = 3;
	// interrupt control fields and source index
	localparam int SSE_IC_REQ = 0;
	localparam int SSE_IC_IE  = 1;
	localparam int SSE_NIRQ   = 3;
	localparam int SSE_IRQ_TX = 0;
	localparam int SSE_IRQ_RX = 1;
	localparam int SSE_IRQ_ER = 2;
	// ==========================================================
	// reset values
	localparam logic [8:0]  SSE_CFG_RST = 9'h000;
	localparam logic [15:0] SSE_BRG_RST = 16'h0001;
	localparam logic [15:0] SSE_BUF_RST = 16'h0000;
	// ==========================================================
	// frame and timing
	localparam int SSE_FRAME_W = 16;
	localparam int SSE_PH_PRE  = 1;
	localparam int SSE_PH_POST = 2;
	localparam int SSE_PER_W   = 19;
	typedef enum logic [1:0] {
		SSE_IDLE = 2'b01,
		SSE_BUSY = 2'b10
	} sse_state_t;
endpackage : sse_pkg

// file: test/sse_far_master.sv
// far-side serial master model: drives shift clock and slave-input data
module sse_far_master (
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// idle state
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
	end

	// ==========================================================
	// one frame, msb first; data moves on falling clock, sampled on rising
	task automatic frame(input logic [15:0] tx, input realtime half, input realtime gap,
		input int glitch, output logic [15:0] rx);
		rx = 16'h0000;
		#3;
		for (int i = 15; i >= 0; i--) begin
			mosi = tx[i];
			#(half);
			sclk = 1'b1;
			rx = {rx[14:0], miso};
			if (i == glitch) begin
				// late change, deliberately inside the latch window
				#4 mosi = ~mosi;
				#(half - 4);
			end else begin
				#(half);
			end
			sclk = 1'b0;
			// stretched low phase mimics a missing clock pulse
			if (i == 8) #(gap);
		end
		#(half);
		// released line: never leave the last bit standing
		mosi = ~mosi;
	endtask : frame
endmodule : sse_far_master

// file: test/testbench.sv
// testbench: slave-mode error detection of the serial channel
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import sse_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        sclk_o;
	logic        sclk_oe;
	logic        miso_o;
	logic        miso_oe;
	logic        mosi_o;
	logic        mosi_oe;
	logic        m_sclk;
	logic        m_mosi;
	logic        rd_dp;
	logic [2:0]  irq_ack;
	logic [2:0]  irq;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	logic [15:0] cap;
	logic [15:0] rx_m;
	logic [15:0] old;
	logic [15:0] mcap;
	int          err_count;
	int          num_checks;
	wire         hready = hreadyout;
	wire         sclk_w = sclk_oe ? sclk_o : m_sclk;
	wire         mosi_w = mosi_oe ? mosi_o : m_mosi;
	wire         miso_w = miso_oe ? miso_o : ~m_mosi;

	sse_core u_sse_core (
		.hclk                       (hclk),
		.hresetn                    (hresetn),
		.hsel                       (hsel),
		.haddr                      (haddr),
		.htrans                     (htrans),
		.hwrite                     (hwrite),
		.hsize                      (hsize),
		.hwdata                     (hwdata),
		.hready                     (hready),
		.hreadyout                  (hreadyout),
		.hresp                      (hresp),
		.hrdata                     (hrdata),
		.sclk_i                     (sclk_w),
		.sclk_o                     (sclk_o),
		.sclk_oe                    (sclk_oe),
		.master_in_slave_out_pin_i  (miso_w),
		.master_in_slave_out_pin_o  (miso_o),
		.master_in_slave_out_pin_oe (miso_oe),
		.master_out_slave_in_pin_i  (mosi_w),
		.master_out_slave_in_pin_o  (mosi_o),
		.master_out_slave_in_pin_oe (mosi_oe),
		.irq_ack                    (irq_ack),
		.irq                        (irq)
	);

	sse_far_master u_sse_far_master (
		.sclk (m_sclk),
		.mosi (m_mosi),
		.miso (miso_w)
	);

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// single word transfer; for reads d is the expected value under mask m
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0000_0000;
		if (!w) exp_q.push_back({m, d});
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : bus

	task automatic ack(input int k);
		@(posedge hclk);
		irq_ack <= 3'(1 << k);
		@(posedge hclk);
		irq_ack <= 3'b000;
	endtask : ack

	task automatic xfer(input logic ld, input logic [15:0] tv, input realtime half,
		input realtime gap, input int gl);
		if (ld) bus(1'b1, SSE_OFF_TB, 32'(tv), 32'h0000_0000);
		repeat (4) @(posedge hclk);
		rx_m = 16'($urandom);
		u_sse_far_master.frame(rx_m, half, gap, gl, cap);
		repeat (8) @(posedge hclk);
	endtask : xfer

	// ==========================================================
	// read data checker: oldest note against the data phase
	always @(posedge hclk) begin
		if (rd_dp) begin
			note = exp_q.pop_front();
			chk(hrdata & note[63:32], note[31:0]);
		end
		rd_dp <= hsel && htrans[1] && !hwrite && hready;
	end

	// master mode: what the channel drives, taken at its own rising clock
	always @(posedge sclk_w) begin
		if (sclk_oe) mcap <= {mcap[14:0], mosi_w};
	end

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		#100_000;
		err_count++;
		$display("Error %0t: watchdog expired", $time);
		close_out();
	end

	// ==========================================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		irq_ack = 3'b000;
		void'($urandom(32'h1ed4_76fd));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, SSE_OFF_CTRL, 32'h0000_0000, '1);
		bus(1'b0, SSE_OFF_BRG, 32'(SSE_BRG_RST), '1);
		bus(1'b0, 8'h1C, 32'h0000_0000, '1);
		// reload 7: 128 ns bit time, matched to the 125 ns far clock
		bus(1'b1, SSE_OFF_BRG, 32'h0000_0007, '0);
		for (int i = 0; i < SSE_NIRQ; i++) bus(1'b1, SSE_OFF_IC[i], 32'h0000_0002, '0);
		bus(1'b1, SSE_OFF_CTRL, 32'h0000_00F1, '0);
		for (int k = 0; k < 3; k++) begin
			old = (k == 1) ? 16'hFFFF : 16'($urandom);
			xfer(1'b1, old, 62.5, 0.0, -1);
			chk(32'(cap), 32'(old));
			if (k == 0) begin
				chk(32'(irq[SSE_IRQ_TX]), 32'h0000_0001);
				chk(32'(irq[SSE_IRQ_RX]), 32'h0000_0001);
				bus(1'b0, SSE_OFF_RB, 32'(rx_m), '1);
				ack(SSE_IRQ_RX);
				bus(1'b0, SSE_OFF_IC[SSE_IRQ_RX], 32'h0000_0002, '1);
			end
		end
		bus(1'b0, SSE_OFF_CTRL, 32'h0000_10F1, '1);
		chk(32'(irq[SSE_IRQ_ER]), 32'h0000_0001);
		bus(1'b0, SSE_OFF_RB, 32'(rx_m), '1);
		ack(SSE_IRQ_ER);
		repeat (2) @(posedge hclk);
		chk(32'(irq[SSE_IRQ_ER]), 32'h0000_0001);
		bus(1'b1, SSE_OFF_CTRL, 32'h0000_1071, '0);
		ack(SSE_IRQ_ER);
		repeat (2) @(posedge hclk);
		chk(32'(irq[SSE_IRQ_ER]), 32'h0000_0000);
		old = rx_m;
		xfer(1'b0, 16'h0000, 62.5, 0.0, -1);
		chk(32'(cap), 32'(old));
		bus(1'b0, SSE_OFF_CTRL, 32'h0000_8071, '1);
		chk(32'(irq[SSE_IRQ_ER]), 32'h0000_0000);
		bus(1'b0, SSE_OFF_RB, 32'(rx_m), '1);
		bus(1'b1, SSE_OFF_CTRL, 32'h0000_80F1, '0);
		xfer(1'b1, 16'($urandom), 62.5, 0.0, 5);
		bus(1'b0, SSE_OFF_CTRL, 32'h0000_20F1, '1);
		bus(1'b0, SSE_OFF_RB, 32'h0000_0000, '0);
		bus(1'b1, SSE_OFF_CTRL, 32'h0000_20F1, '0);
		// matched-rate frame with a missing pulse, fast frame, fast frame with auto reinit;
		// each reinit drops the frame, so the next pulse starts an underrun
		for (int j = 0; j < 3; j++) begin
			xfer(1'b1, 16'($urandom), j ? 20.0 : 62.5, j ? 0.0 : 1000.0, -1);
			bus(1'b0, SSE_OFF_CTRL, j == 2 ? 32'h0000_C000 : 32'h0000_4000, 32'h0000_F000);
			bus(1'b0, SSE_OFF_RB, 32'h0000_0000, '0);
			bus(1'b1, SSE_OFF_CTRL, j == 1 ? 32'h0000_C1F1 : 32'h0000_C0F1, '0);
		end
		// master mode: own clock out, receive on the other data pin
		bus(1'b1, SSE_OFF_CTRL, 32'h0000_00F3, '0);
		old = 16'($urandom);
		bus(1'b1, SSE_OFF_TB, 32'(old), '0);
		chk(32'({sclk_oe, mosi_oe, miso_oe}), 32'h0000_0006);
		repeat (400) @(posedge hclk);
		chk(32'(mcap), 32'(old));
		bus(1'b0, SSE_OFF_RB, 32'({16{~m_mosi}}), '1);
		bus(1'b0, SSE_OFF_CTRL, 32'h0000_00F3, '1);
		repeat (4) @(posedge hclk);
		chk(32'(exp_q.size()), 32'h0000_0000);
		close_out();
	end
endmodule : testbench
